// ===== hw/switch_forwarding.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: With IGMP trapping on, IGMP frames go only to port 3.
// RULE2: IGMP means IPv4 (Ethernet II or SNAP) with protocol 2.
// RULE3: Static multicast entries restrict forwarding to their listed ports.
// RULE4: IGMP trapping is switched on by its enable bit.
// RULE5: Upstream special tagging needs both its enable bits set.
// RULE6: Frames received on receive-sniff ports are copied to the sniffer.
// RULE7: Optionally, errored received frames are still copied to the sniffer.
// RULE8: Frames sent on transmit-sniff ports are copied to the sniffer.
// RULE9: AND mode mirrors only receive-sniff to transmit-sniff traffic.
// RULE10: Sniff roles are per port; several ports may share them.
// RULE11: Sixteen-entry table maps 12-bit VID to 4-bit FID.
// RULE12: Untagged or null-VID frames use the ingress port default VID.
// RULE13: In VLAN mode an unknown VID drops the frame, no learning.
// RULE14: No usable static entry: dynamic port if found, else flood members.
// RULE15: Static hit used when FID flag clear or FID matches.
// RULE16: Unknown source is learned; known source refreshes its time stamp.
// RULE17: Ingress filtering and non-PVID discard are enabled per port.
// RULE18: Split queue per port by bit or strap.
// RULE19: Strict scheme sends low only when the high queue is empty.
// RULE20: Ratio schemes send one low after 10, 5 or 2 highs.
// RULE21: Scheme chosen by a two-bit field or two straps.
// RULE22: Scheme codes: 00 strict, 01 10:1, 10 5:1, 11 2:1.
// RULE23: Unsplit queue gives high and low equal precedence.
// RULE24: Port priority marks every ingress frame high priority.
// RULE25: Special tag mask is 0001 from port one, 0010 from two.
module switch_forwarding #(
  parameter int VT_N = swf_pkg::VT_N
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration
  input wire logic igmp_en,
  input wire logic stag_en_global,
  input wire logic stag_en_cpu,
  input wire logic mirror_and,
  input wire logic mirror_bad,
  input wire logic vlan_mode,
  input wire logic [swf_pkg::NP-1:0] rx_sniff,
  input wire logic [swf_pkg::NP-1:0] tx_sniff,
  input wire logic [swf_pkg::NP-1:0] sniffer,
  input wire logic [swf_pkg::NP-1:0] ingress_filter,
  input wire logic [swf_pkg::NP-1:0] discard_non_pvid,
  input wire logic [swf_pkg::VID_W-1:0] pvid_p1,
  input wire logic [swf_pkg::VID_W-1:0] pvid_p2,
  input wire logic [swf_pkg::VID_W-1:0] pvid_p3,
  // Priority configuration and straps
  input wire logic [swf_pkg::NP-1:0] split_queue,
  input wire logic [swf_pkg::NP-1:0] split_queue_strap,
  input wire logic [swf_pkg::NP-1:0] port_priority,
  input wire logic [swf_pkg::NP-1:0] port_priority_strap,
  input wire logic [1:0] scheme_sel,
  input wire logic scheme_select_strap_hi,
  input wire logic scheme_select_strap_lo,
  // VLAN table write
  input wire logic vt_we,
  input wire logic [3:0] vt_idx,
  input wire logic vt_wvalid,
  input wire logic [swf_pkg::VID_W-1:0] vt_wvid,
  input wire logic [swf_pkg::FID_W-1:0] vt_wfid,
  input wire logic [swf_pkg::NP-1:0] vt_wmem,
  // Frame header
  input wire logic hdr_valid,
  input wire logic [1:0] hdr_port,
  input wire logic hdr_tagged,
  input wire logic [swf_pkg::VID_W-1:0] hdr_vid,
  input wire logic hdr_ip_ethii,
  input wire logic hdr_ip_snap,
  input wire logic [3:0] hdr_ip_ver,
  input wire logic [7:0] hdr_ip_proto,
  input wire logic hdr_rx_error,
  // Address table results
  input wire logic st_hit,
  input wire logic st_use_fid,
  input wire logic [swf_pkg::FID_W-1:0] st_fid,
  input wire logic [swf_pkg::NP-1:0] st_ports,
  input wire logic dyn_hit,
  input wire logic [1:0] dyn_port,
  input wire logic sa_hit,
  // Forwarding decision
  output logic fwd_valid,
  output logic [swf_pkg::NP-1:0] fwd_ports,
  output logic [swf_pkg::NP-1:0] fwd_hiq,
  output logic [swf_pkg::FID_W-1:0] fwd_fid,
  output logic [3:0] fwd_tag_mask,
  output logic learn_pulse,
  output logic refresh_pulse,
  // Transmit scheduling
  input wire logic [swf_pkg::NP-1:0] q_hi_busy,
  input wire logic [swf_pkg::NP-1:0] q_lo_busy,
  input wire logic [swf_pkg::NP-1:0] tx_done,
  output logic [swf_pkg::NP-1:0] tx_pick_hi,
  output logic [swf_pkg::NP-1:0] tx_pick_lo
);
  import swf_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // VLAN table
  // ****************************************
  logic [VT_N-1:0] vt_ok;
  logic [VID_W-1:0] vt_vid [VT_N];
  logic [FID_W-1:0] vt_fid [VT_N];
  logic [NP-1:0] vt_mem [VT_N];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vt_ok <= '0;
    end else if (vt_we) begin
      vt_ok[vt_idx] <= vt_wvalid;
    end
  end

  // Contents need no reset: vt_ok gates every entry
  always_ff @(posedge clk) begin
    if (vt_we) begin
      vt_vid[vt_idx] <= vt_wvid;
      vt_fid[vt_idx] <= vt_wfid;
      vt_mem[vt_idx] <= vt_wmem;
    end
  end

  logic [VID_W-1:0] pvid_in;
  assign pvid_in = (hdr_port == P1_IDX) ? pvid_p1 :
                   (hdr_port == P2_IDX) ? pvid_p2 : pvid_p3;
  wire null_tag = hdr_tagged && (hdr_vid == NULL_VID);
  wire [VID_W-1:0] lk_vid = (!hdr_tagged || null_tag) ? pvid_in : hdr_vid; // RULE12

  wire [VT_N-1:0] vt_match;
  genvar gi;
  generate
    for (gi = 0; gi < VT_N; gi++) begin : g_vt
      assign vt_match[gi] = vt_ok[gi] && (vt_vid[gi] == lk_vid); // RULE11
    end
  endgenerate

  // Duplicate VIDs are a software fault; matches are OR-merged
  logic [FID_W-1:0] hit_fid;
  logic [NP-1:0] hit_mem;
  always_comb begin
    hit_fid = '0;
    hit_mem = '0;
    for (int i = 0; i < VT_N; i++) begin
      if (vt_match[i]) begin
        hit_fid = hit_fid | vt_fid[i];
        hit_mem = hit_mem | vt_mem[i];
      end
    end
  end

  // ****************************************
  // Lookup and filtering
  // ****************************************
  wire [NP-1:0] in_oh = 3'h1 << hdr_port;
  wire vid_bad = vlan_mode && (vt_match == '0); // RULE13
  wire filt_drop = ingress_filter[hdr_port] && vlan_mode && ((hit_mem & in_oh) == '0); // RULE17
  wire npvid_drop = discard_non_pvid[hdr_port] && hdr_tagged && !null_tag
                    && (hdr_vid != pvid_in); // RULE17
  wire drop_lkp = vid_bad || filt_drop || npvid_drop;
  wire [FID_W-1:0] fid = vlan_mode ? hit_fid : FID_NOVLAN;
  wire [NP-1:0] members = vlan_mode ? hit_mem : ALL_PORTS;
  wire static_ok = st_hit && (!st_use_fid || (st_fid == fid)); // RULE15
  wire [NP-1:0] dyn_oh = 3'h1 << dyn_port;
  // Flooding never sends a frame back out of its ingress port
  wire [NP-1:0] lookup = static_ok ? st_ports : // RULE3 RULE15
                         dyn_hit ? dyn_oh : (members & ~in_oh); // RULE14
  wire is_igmp = (hdr_ip_ethii || hdr_ip_snap) && (hdr_ip_ver == IP_V4)
                 && (hdr_ip_proto == PROTO_IGMP); // RULE2
  wire trap = igmp_en && is_igmp; // RULE4
  wire [NP-1:0] base = trap ? CPU_PORTS : lookup; // RULE1
  wire [NP-1:0] good_ports = (drop_lkp || hdr_rx_error) ? NO_PORTS : base;

  // ****************************************
  // Mirroring
  // ****************************************
  wire rx_ok = rx_sniff[hdr_port] && !drop_lkp && (!hdr_rx_error || mirror_bad); // RULE6 RULE7
  wire tx_m = (good_ports & tx_sniff) != '0; // RULE8 RULE10
  wire mir = mirror_and ? (rx_ok && tx_m) : (rx_ok || tx_m); // RULE9
  wire [NP-1:0] next_ports = good_ports | (mir ? sniffer : NO_PORTS);

  // ****************************************
  // Priority marking and special tag
  // ****************************************
  wire [NP-1:0] split_eff = split_queue | split_queue_strap; // RULE18
  wire [NP-1:0] pri_eff = port_priority | port_priority_strap;
  wire high = pri_eff[hdr_port]; // RULE24
  wire [NP-1:0] next_hiq = {NP{high}} & split_eff & next_ports; // RULE24
  wire stag_on = stag_en_global && stag_en_cpu; // RULE5
  wire [3:0] next_tag = (!stag_on || !next_ports[P3_IDX] || hdr_port == P3_IDX) ? TAGMASK_NONE :
                        (hdr_port == P1_IDX) ? TAGMASK_P1 : TAGMASK_P2; // RULE25
  wire learn_ok = hdr_valid && !vid_bad && !hdr_rx_error;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fwd_valid <= 1'b0;
      fwd_ports <= NO_PORTS;
      fwd_hiq <= NO_PORTS;
      fwd_fid <= FID_NOVLAN;
      fwd_tag_mask <= TAGMASK_NONE;
      learn_pulse <= 1'b0;
      refresh_pulse <= 1'b0;
    end else begin
      fwd_valid <= hdr_valid;
      learn_pulse <= learn_ok && !sa_hit; // RULE16
      refresh_pulse <= learn_ok && sa_hit; // RULE16
      if (hdr_valid) begin
        fwd_ports <= next_ports;
        fwd_hiq <= next_hiq;
        fwd_fid <= fid;
        fwd_tag_mask <= next_tag;
      end
    end
  end

  // ****************************************
  // Transmit scheduling
  // ****************************************
  wire [1:0] scheme = scheme_sel | {scheme_select_strap_hi, scheme_select_strap_lo}; // RULE21
  wire [CNT_W-1:0] ratio = (scheme == SCH_R10) ? RATIO_10 : // RULE22
                           (scheme == SCH_R5) ? RATIO_5 : RATIO_2;
  wire strict = scheme == SCH_STRICT;

  generate
    for (gi = 0; gi < NP; gi++) begin : g_sch
      logic [CNT_W-1:0] hi_cnt;
      // Unsplit ports keep everything in one queue, the low one
      assign tx_pick_hi[gi] = split_eff[gi] && q_hi_busy[gi]
                              && (strict || !q_lo_busy[gi] || hi_cnt < ratio); // RULE19 RULE20
      assign tx_pick_lo[gi] = q_lo_busy[gi] && !tx_pick_hi[gi]; // RULE23
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          hi_cnt <= '0;
        end else if (tx_done[gi] && tx_pick_lo[gi]) begin
          hi_cnt <= '0; // RULE20
        end else if (tx_done[gi] && tx_pick_hi[gi] && q_lo_busy[gi] && !strict
                     && hi_cnt < ratio) begin
          hi_cnt <= hi_cnt + 1'b1; // RULE20
        end
      end
      strict_order_a: assert property ( // RULE19
        split_eff[gi] && strict && q_hi_busy[gi] |-> !tx_pick_lo[gi])
        else $error("low sent while high waits");
      ratio_turn_a: assert property ( // RULE20
        split_eff[gi] && !strict && q_hi_busy[gi] && tx_pick_lo[gi] |-> hi_cnt == ratio)
        else $error("low sent early");
      unsplit_queue_a: assert property ( // RULE23
        !split_eff[gi] |-> !tx_pick_hi[gi])
        else $error("high queue used unsplit");
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  igmp_trap_a: assert property ( // RULE1
    hdr_valid && trap && !drop_lkp && !hdr_rx_error && !mir |=> fwd_ports == CPU_PORTS)
    else $error("igmp not trapped");
  vid_drop_a: assert property ( // RULE13
    hdr_valid && vid_bad |=> fwd_valid && fwd_ports == NO_PORTS && !learn_pulse)
    else $error("bad vid passed");
  static_fwd_a: assert property ( // RULE15
    hdr_valid && static_ok && !trap && !drop_lkp && !hdr_rx_error && !mir
    |=> fwd_ports == $past(st_ports))
    else $error("static ports ignored");
  dyn_fwd_a: assert property ( // RULE14
    hdr_valid && !static_ok && dyn_hit && !trap && !drop_lkp && !hdr_rx_error && !mir
    |=> fwd_ports == $past(dyn_oh))
    else $error("dynamic port ignored");
  flood_member_a: assert property ( // RULE14
    hdr_valid && !static_ok && !dyn_hit && !trap && !drop_lkp && !hdr_rx_error && !mir
    |=> (fwd_ports & ~$past(members & ~in_oh)) == NO_PORTS)
    else $error("flood left its members");
  filter_drop_a: assert property ( // RULE17
    hdr_valid && vlan_mode && ingress_filter[hdr_port] && (hit_mem & in_oh) == NO_PORTS
    |=> fwd_valid && fwd_ports == NO_PORTS)
    else $error("filtered frame passed");
  non_pvid_a: assert property ( // RULE17
    hdr_valid && discard_non_pvid[hdr_port] && hdr_tagged && hdr_vid != NULL_VID
    && hdr_vid != pvid_in |=> fwd_valid && fwd_ports == NO_PORTS)
    else $error("non pvid frame passed");
  mirror_and_a: assert property ( // RULE9
    hdr_valid && mirror_and && !(rx_sniff[hdr_port] && tx_m)
    |=> fwd_ports == $past(good_ports)) else $error("and mirror leaked");
  sniff_copy_a: assert property ( // RULE6
    hdr_valid && !mirror_and && rx_ok
    |=> (fwd_ports & $past(sniffer)) == $past(sniffer)) else $error("sniff copy lost");
  tx_copy_a: assert property ( // RULE8
    hdr_valid && !mirror_and && (good_ports & tx_sniff) != NO_PORTS
    |=> (fwd_ports & $past(sniffer)) == $past(sniffer))
    else $error("transmit copy lost");
  bad_frame_a: assert property ( // RULE7
    hdr_valid && hdr_rx_error && !mirror_bad |=> fwd_ports == NO_PORTS)
    else $error("errored frame sent");
  learn_once_a: assert property ( // RULE16
    learn_ok |=> learn_pulse != refresh_pulse)
    else $error("learn and refresh clash");
  port_pri_a: assert property ( // RULE24
    hdr_valid && pri_eff[hdr_port] |=> fwd_hiq == ($past(split_eff) & fwd_ports))
    else $error("priority frame not high");
  low_pri_a: assert property ( // RULE24
    hdr_valid && !pri_eff[hdr_port] |=> fwd_hiq == NO_PORTS)
    else $error("plain frame marked high");
  tag_mask_a: assert property ( // RULE25
    hdr_valid && stag_on && hdr_port == P1_IDX && next_ports[P3_IDX]
    |=> fwd_tag_mask == TAGMASK_P1) else $error("tag mask wrong");
endmodule

// ===== hw/swf_pkg.sv
package swf_pkg;
  localparam int NP = 3;
  localparam int VT_N = 16;
  localparam int VID_W = 12;
  localparam int FID_W = 4;
  localparam int CNT_W = 4;
  localparam logic [3:0] IP_V4 = 4'h4;
  localparam logic [7:0] PROTO_IGMP = 8'h02;
  localparam logic [11:0] NULL_VID = 12'h000;
  localparam logic [2:0] CPU_PORTS = 3'h4;
  localparam logic [2:0] ALL_PORTS = 3'h7;
  localparam logic [2:0] NO_PORTS = 3'h0;
  localparam logic [1:0] P1_IDX = 2'h0;
  localparam logic [1:0] P2_IDX = 2'h1;
  localparam logic [1:0] P3_IDX = 2'h2;
  localparam logic [3:0] TAGMASK_P1 = 4'h1;
  localparam logic [3:0] TAGMASK_P2 = 4'h2;
  localparam logic [3:0] TAGMASK_NONE = 4'h0;
  localparam logic [1:0] SCH_STRICT = 2'h0;
  localparam logic [1:0] SCH_R10 = 2'h1;
  localparam logic [1:0] SCH_R5 = 2'h2;
  localparam logic [1:0] SCH_R2 = 2'h3;
  localparam logic [3:0] RATIO_10 = 4'hA;
  localparam logic [3:0] RATIO_5 = 4'h5;
  localparam logic [3:0] RATIO_2 = 4'h2;
  localparam logic [3:0] FID_NOVLAN = 4'h0;
endpackage

// ===== sim/host_cpu_model.sv
`timescale 1ns/1ps
// ********************************
// Processor behind port 3
// ********************************
module host_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Software intent and switch decision
  input wire logic igmp_want,
  input wire logic fwd_valid,
  input wire logic [2:0] fwd_ports,
  // Configuration set by software, and count of frames sent to the processor
  output logic igmp_en,
  output logic stag_en_global,
  output logic stag_en_cpu,
  output int rx_count
);
  // Trapping is useless without the source tag, so both go on together
  assign igmp_en = igmp_want;
  assign stag_en_global = igmp_want;
  assign stag_en_cpu = igmp_want;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_count <= 0;
    end else if (fwd_valid && fwd_ports[2]) begin
      rx_count <= rx_count + 1;
    end
  end
endmodule

// ===== sim/switch_forwarding_tb_top.sv
`timescale 1ns/1ps
// ********************************
// Forwarding bench
// ********************************
module switch_forwarding_tb_top;
  import swf_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, igmp_want = 1'b0, mirror_and = 1'b0, mirror_bad = 1'b0;
  logic vlan_mode = 1'b0, vt_we = 1'b0, vt_wvalid = 1'b1, hdr_valid = 1'b0, hdr_tagged = 1'b0;
  logic hdr_ip_ethii = 1'b0, hdr_ip_snap = 1'b1, hdr_rx_error = 1'b0, st_hit = 1'b0;
  logic st_use_fid = 1'b0, dyn_hit = 1'b1, sa_hit = 1'b0;
  logic scheme_select_strap_hi = 1'b0, scheme_select_strap_lo = 1'b0;
  logic [2:0] rx_sniff = 3'h0, tx_sniff = 3'h0, sniffer = 3'h4, split_queue = 3'h0;
  logic [2:0] port_priority = 3'h0, port_priority_strap = 3'h0, split_queue_strap = 3'h0;
  logic [2:0] ingress_filter = 3'h0, discard_non_pvid = 3'h0, vt_wmem = 3'h3, st_ports = 3'h3;
  logic [2:0] q_hi_busy = 3'h0, q_lo_busy = 3'h0, tx_done = 3'h0;
  logic [1:0] scheme_sel = 2'h0, hdr_port = 2'h0, dyn_port = 2'h1;
  logic [3:0] vt_idx = 4'hF, vt_wfid = 4'h3, hdr_ip_ver = 4'h4, st_fid = 4'h9;
  logic [7:0] hdr_ip_proto = 8'h02;
  logic [11:0] pvid_p1 = 12'h005, pvid_p2 = 12'h006, pvid_p3 = 12'h007;
  logic [11:0] vt_wvid = 12'h005, hdr_vid = 12'h000;
  logic igmp_en, stag_en_global, stag_en_cpu, fwd_valid, learn_pulse, refresh_pulse;
  logic [2:0] fwd_ports, fwd_hiq, tx_pick_hi, tx_pick_lo;
  logic [3:0] fwd_fid, fwd_tag_mask;
  int rx_count, err_total = 0, n_compared = 0;
  int ratio[3] = '{10, 5, 2};
  logic [1:0] code[3] = '{SCH_R10, SCH_R5, SCH_R2};

  switch_forwarding dut (.*);
  host_cpu_model cpu (.*);

  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits a falling edge first so back-to-back calls never touch hdr_valid twice at once
  task automatic send(input logic [1:0] p, input logic [2:0] exp);
    @(negedge clk);
    hdr_port = p;
    hdr_valid = 1'b1;
    @(negedge clk);
    hdr_valid = 1'b0;
    cmp({3'h0, fwd_valid}, 4'h1);
    cmp({1'b0, fwd_ports}, {1'b0, exp});
  endtask
  task automatic done(input logic [2:0] m);
    @(negedge clk);
    tx_done = m;
    @(negedge clk);
    tx_done = 3'h0;
  endtask
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    #(3000 * 100);
    err_total++;
    test_done();
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    igmp_want = 1'b1;
    send(P1_IDX, CPU_PORTS);
    cmp(fwd_tag_mask, TAGMASK_P1);
    cmp({3'h0, learn_pulse}, 4'h1);
    hdr_ip_snap = 1'b0;
    hdr_ip_ethii = 1'b1;
    sa_hit = 1'b1;
    send(P2_IDX, CPU_PORTS);
    cmp(fwd_tag_mask, TAGMASK_P2);
    cmp({3'h0, refresh_pulse}, 4'h1);
    hdr_ip_proto = 8'h03;
    send(P1_IDX, 3'h2);
    cmp(rx_count[3:0], 4'h2);
    hdr_ip_proto = 8'h02;
    hdr_ip_ver = 4'h6;
    send(P1_IDX, 3'h2);
    hdr_ip_ver = 4'h4;
    igmp_want = 1'b0;
    send(P1_IDX, 3'h2);
    rx_sniff = 3'h1;
    send(P1_IDX, 3'h6);
    sniffer = 3'h1;
    rx_sniff = 3'h0;
    tx_sniff = 3'h2;
    send(P3_IDX, 3'h3);
    sniffer = 3'h4;
    rx_sniff = 3'h1;
    mirror_and = 1'b1;
    send(P1_IDX, 3'h6);
    tx_sniff = 3'h0;
    send(P1_IDX, 3'h2);
    mirror_and = 1'b0;
    mirror_bad = 1'b1;
    hdr_rx_error = 1'b1;
    send(P1_IDX, 3'h4);
    mirror_bad = 1'b0;
    send(P1_IDX, NO_PORTS);
    hdr_rx_error = 1'b0;
    rx_sniff = 3'h0;
    st_hit = 1'b1;
    send(P3_IDX, 3'h3);
    st_use_fid = 1'b1;
    send(P3_IDX, 3'h2);
    st_hit = 1'b0;
    dyn_hit = 1'b0;
    send(P1_IDX, 3'h6);
    vt_we = 1'b1;
    @(negedge clk);
    vt_we = 1'b0;
    vlan_mode = 1'b1;
    send(P1_IDX, 3'h2);
    cmp(fwd_fid, 4'h3);
    hdr_tagged = 1'b1;
    send(P1_IDX, 3'h2);
    hdr_vid = 12'h005;
    send(P2_IDX, 3'h1);
    discard_non_pvid = 3'h2;
    send(P2_IDX, NO_PORTS);
    discard_non_pvid = 3'h0;
    ingress_filter = 3'h4;
    send(P3_IDX, NO_PORTS);
    ingress_filter = 3'h0;
    hdr_vid = 12'h009;
    sa_hit = 1'b0;
    send(P1_IDX, NO_PORTS);
    cmp({3'h0, learn_pulse}, 4'h0);
    vlan_mode = 1'b0;
    hdr_tagged = 1'b0;
    dyn_hit = 1'b1;
    split_queue_strap = 3'h2;
    port_priority = 3'h1;
    send(P1_IDX, 3'h2);
    cmp({1'b0, fwd_hiq}, 4'h2);
    split_queue = 3'h1;
    port_priority = 3'h0;
    port_priority_strap = 3'h4;
    dyn_port = 2'h0;
    send(P3_IDX, 3'h1);
    cmp({1'b0, fwd_hiq}, 4'h1);
    port_priority_strap = 3'h0;
    send(P3_IDX, 3'h1);
    cmp({1'b0, fwd_hiq}, 4'h0);
    split_queue = 3'h0;
    q_hi_busy = 3'h3;
    q_lo_busy = 3'h3;
    #1 cmp({2'h0, tx_pick_hi[1], tx_pick_lo[1]}, 4'h2);
    cmp({3'h0, tx_pick_hi[0]}, 4'h0);
    cmp({3'h0, tx_pick_lo[0]}, 4'h1);
    @(negedge clk);
    q_hi_busy = 3'h1;
    #1 cmp({3'h0, tx_pick_lo[1]}, 4'h1);
    @(negedge clk);
    q_hi_busy = 3'h3;
    foreach (ratio[i]) begin
      // The middle scheme comes from the straps alone
      scheme_sel = (i == 1) ? SCH_STRICT : code[i];
      {scheme_select_strap_hi, scheme_select_strap_lo} = (i == 1) ? code[i] : 2'h0;
      repeat (ratio[i]) begin
        #1 cmp({3'h0, tx_pick_hi[1]}, 4'h1);
        done(3'h2);
      end
      cmp({3'h0, tx_pick_lo[1]}, 4'h1);
      done(3'h2);
    end
    test_done();
  end
endmodule
